// >>> bench/pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// =========================================================
// external pins: chip drive wins where enabled, else the outside
module pin_model
   import pio_status_pkg::*;
(
   input wire logic [PIN_COUNT-1:0] i_drive,
   input wire logic [PIN_COUNT-1:0] i_oe,
   input wire logic [PIN_COUNT-1:0] i_ext,
   output logic [PIN_COUNT-1:0] o_level
);

   assign o_level = (i_drive & i_oe) | (i_ext & ~i_oe);

endmodule : pin_model

`default_nettype wire

// >>> bench/tb_pio_status_irq.sv
`timescale 1ns/1ps
`default_nettype none

module tb_pio_status_irq
   import pio_status_pkg::*;
;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] addr = 8'h00;
   logic [DATA_W-1:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic [PIN_COUNT-1:0] owned = 32'h0000_0000;
   logic [PIN_COUNT-1:0] is_out = 32'h0000_0000;
   logic [PIN_COUNT-1:0] ext = 32'hA5A5_0000;
   logic [PIN_COUNT-1:0] level;
   logic [PIN_COUNT-1:0] pin_out;
   logic [PIN_COUNT-1:0] pin_oe;
   logic irq;
   int err_count = 0;
   int n_tests = 0;

   always #10 clock = ~clock;

   pio_status_irq i_pio_status_irq (
      .I_CLOCK(clock),
      .I_RST(rst),
      .i_ADDR(addr),
      .i_WDATA(wdata),
      .i_WR(wr),
      .i_RD(rd),
      .o_RDATA(rdata),
      .i_PIN_OWNED(owned),
      .i_PIN_IS_OUTPUT(is_out),
      .i_PIN_IN(level),
      .o_PIN_OUT(pin_out),
      .o_PIN_OE(pin_oe),
      .o_IRQ(irq)
   );

   pin_model i_pin_model (
      .i_drive(pin_out),
      .i_oe(pin_oe),
      .i_ext(ext),
      .o_level(level)
   );

   // =========================================================
   // compare, bus and closing tasks
   task automatic chk(input string what, input logic [DATA_W-1:0] exp,
                      input logic [DATA_W-1:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit

   task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      chk("read data", exp, rdata);
   endtask : reg_read

   task automatic idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : idle

   task automatic toggle(input logic [PIN_COUNT-1:0] bits);
      @(posedge clock);
      ext <= ext ^ bits;
      idle(6);
   endtask : toggle

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude

   // =========================================================
   // tests
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      idle(8);
      reg_read(OUTPUT_DATA_READBACK_OFS, OUTPUT_DATA_RST);
      reg_read(CHANGE_IRQ_MASK_OFS, CHANGE_IRQ_MASK_RST);
      reg_read(CHANGE_STATUS_OFS, CHANGE_STATUS_RST);
      reg_read(8'h20, UNMAPPED_READ);
      reg_read(PIN_LEVEL_READBACK_OFS, 32'hA5A5_0000);
      reg_write(SET_OUTPUT_DATA_OFS, 32'h8000_00F0);
      reg_write(CLEAR_OUTPUT_DATA_OFS, 32'h0000_0030);
      reg_write(OUTPUT_DATA_READBACK_OFS, 32'hFFFF_FFFF);
      reg_read(OUTPUT_DATA_READBACK_OFS, 32'h8000_00C0);
      chk("pin enable", 32'h0000_0000, pin_oe);
      @(posedge clock);
      owned <= 32'h8000_00FF;
      is_out <= 32'h0000_00CF;
      idle(8);
      chk("pin enable", 32'h0000_00CF, pin_oe);
      chk("pin out", 32'h8000_00C0, pin_out);
      reg_read(PIN_LEVEL_READBACK_OFS, 32'hA5A5_00C0);
      reg_read(CHANGE_STATUS_OFS, 32'h0000_00C0);
      chk_bit("irq", 1'b0, irq);
      reg_write(CHANGE_IRQ_ENABLE_OFS, 32'h0001_0003);
      reg_write(CHANGE_IRQ_DISABLE_OFS, 32'h0000_0001);
      reg_write(CHANGE_IRQ_ENABLE_OFS, 32'h0000_0000);
      reg_write(CHANGE_IRQ_DISABLE_OFS, 32'h0000_0000);
      reg_read(CHANGE_IRQ_MASK_OFS, 32'h0001_0002);
      toggle(32'h0000_0010);
      chk_bit("irq", 1'b0, irq);
      reg_read(CHANGE_STATUS_OFS, 32'h0000_0010);
      toggle(32'h0000_0020);
      toggle(32'h0000_0020);
      toggle(32'h0001_0000);
      chk_bit("irq", 1'b1, irq);
      reg_read(CHANGE_STATUS_OFS, 32'h0001_0020);
      chk_bit("irq", 1'b0, irq);
      reg_read(CHANGE_STATUS_OFS, 32'h0000_0000);
      reg_read(PIN_LEVEL_READBACK_OFS, 32'hA5A4_00D0);
      reg_write(CHANGE_IRQ_DISABLE_OFS, 32'h0001_0000);
      toggle(32'h0001_0000);
      chk_bit("irq", 1'b0, irq);
      reg_read(CHANGE_STATUS_OFS, 32'h0001_0000);
      // =========================================================
      // driven pin raises a masked-in change, then reset mid-run
      reg_write(SET_OUTPUT_DATA_OFS, 32'h0000_0002);
      idle(6);
      chk_bit("irq", 1'b1, irq);
      @(posedge clock);
      rst <= 1'b1;
      idle(2);
      chk_bit("irq in reset", 1'b0, irq);
      chk("pin out in reset", OUTPUT_DATA_RST, pin_out);
      @(posedge clock);
      rst <= 1'b0;
      idle(8);
      reg_read(CHANGE_STATUS_OFS, CHANGE_STATUS_RST);
      reg_read(CHANGE_IRQ_MASK_OFS, CHANGE_IRQ_MASK_RST);
      reg_read(PIN_LEVEL_READBACK_OFS, 32'hA5A5_0010);
      conclude();
   end

   initial begin
      #(20 * 4000);
      err_count++;
      conclude();
   end

endmodule : tb_pio_status_irq

`default_nettype wire

// >>> rtl/pin_level_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_level_sync
   import pio_status_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [PIN_COUNT-1:0] i_pins,
   output pin_sense_type o_sense
);

   // =========================================================
   // three-stage capture, level accepted when stages 2 and 3 agree
   logic [PIN_COUNT-1:0] s1_q;
   logic [PIN_COUNT-1:0] s2_q;
   logic [PIN_COUNT-1:0] s3_q;
   logic [PIN_COUNT-1:0] level_q;
   logic [PIN_COUNT-1:0] change_q;
   logic [PIN_COUNT-1:0] primed_q;
   logic [2:0] fill_q;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         s1_q <= PIN_LEVEL_RST;
         s2_q <= PIN_LEVEL_RST;
         s3_q <= PIN_LEVEL_RST;
      end else begin
         s1_q <= i_pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // stages hold real pin samples only once fill_q is all ones
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         fill_q <= '0;
      end else begin
         fill_q <= {fill_q[1:0], 1'b1};
      end
   end

   genvar g;
   generate
      for (g = 0; g < PIN_COUNT; g++) begin : g_pin
         always_ff @(posedge i_clock or posedge i_rst) begin
            if (i_rst) begin
               level_q[g] <= PIN_LEVEL_RST[g];
               change_q[g] <= 1'b0;
               primed_q[g] <= 1'b0;
            end else begin
               change_q[g] <= 1'b0;
               // first settled sample after reset loads the level silently
               if (fill_q[2] && (s2_q[g] == s3_q[g])) begin
                  level_q[g] <= s3_q[g];
                  primed_q[g] <= 1'b1;
                  // both edge directions count
                  change_q[g] <= primed_q[g] && (s3_q[g] != level_q[g]);
               end
            end
         end
      end
   endgenerate

   assign o_sense.level = level_q;
   assign o_sense.change = change_q;

endmodule : pin_level_sync

`default_nettype wire

// >>> rtl/pio_status_irq.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - output readback returns last programmed values
// - pin driven only when owned and output
// - pin readback returns live pin level
// - pin readback valid for every pin once the sync stages have filled after reset
// - enable write of one sets mask
// - enable and disable ignore pin ownership
// - disable write clears mask, detection continues
// - mask readable, updated by writes, resets zero
// - record rising and falling level changes
// - detect changes on every pin, except the first settled sample after reset
// - status clears on read and reset
// - status bit shows change since last read
// - set write of one raises output value
// - clear write of one lowers output value
module pio_status_irq
   import pio_status_pkg::*;
(
   input wire logic I_CLOCK,
   input wire logic I_RST,
   input wire logic [ADDR_W-1:0] i_ADDR,
   input wire logic [DATA_W-1:0] i_WDATA,
   input wire logic i_WR,
   input wire logic i_RD,
   output logic [DATA_W-1:0] o_RDATA,
   input wire logic [PIN_COUNT-1:0] i_PIN_OWNED,
   input wire logic [PIN_COUNT-1:0] i_PIN_IS_OUTPUT,
   input wire logic [PIN_COUNT-1:0] i_PIN_IN,
   output logic [PIN_COUNT-1:0] o_PIN_OUT,
   output logic [PIN_COUNT-1:0] o_PIN_OE,
   output logic o_IRQ
);

   // =========================================================
   // carriers
   bus_req_type req;
   pin_ctrl_type ctrl;
   pin_sense_type sense;

   assign req.addr = i_ADDR;
   assign req.wdata = i_WDATA;
   assign req.wr = i_WR;
   assign req.rd = i_RD;
   assign ctrl.owned = i_PIN_OWNED;
   assign ctrl.is_output = i_PIN_IS_OUTPUT;

   // =========================================================
   // pin sensing, independent of ownership or direction
   pin_level_sync i_pin_level_sync (
      .i_clock(I_CLOCK),
      .i_rst(I_RST),
      .i_pins(i_PIN_IN),
      .o_sense(sense)
   );

   // =========================================================
   // write decode
   logic wr_set;
   logic wr_clr;
   logic wr_ien;
   logic wr_idis;
   logic rd_status;

   assign wr_set = req.wr && (req.addr == SET_OUTPUT_DATA_OFS);
   assign wr_clr = req.wr && (req.addr == CLEAR_OUTPUT_DATA_OFS);
   assign wr_ien = req.wr && (req.addr == CHANGE_IRQ_ENABLE_OFS);
   assign wr_idis = req.wr && (req.addr == CHANGE_IRQ_DISABLE_OFS);
   assign rd_status = req.rd && (req.addr == CHANGE_STATUS_OFS);

   // =========================================================
   // programmed output data
   logic [DATA_W-1:0] output_data_q;
   logic [DATA_W-1:0] output_data_d;

   always_comb begin
      output_data_d = output_data_q;
      if (wr_set) begin
         output_data_d = output_data_q | req.wdata;
      end
      if (wr_clr) begin
         output_data_d = output_data_q & ~req.wdata;
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         output_data_q <= OUTPUT_DATA_RST;
      end else begin
         output_data_q <= output_data_d;
      end
   end

   // value is held always, driven only when owned and output
   assign o_PIN_OUT = output_data_q;
   assign o_PIN_OE = ctrl.owned & ctrl.is_output;

   // =========================================================
   // interrupt mask, no ownership term in the update
   logic [DATA_W-1:0] irq_mask_q;
   logic [DATA_W-1:0] irq_mask_d;

   always_comb begin
      irq_mask_d = irq_mask_q;
      if (wr_ien) begin
         irq_mask_d = irq_mask_q | req.wdata;
      end
      if (wr_idis) begin
         irq_mask_d = irq_mask_q & ~req.wdata;
      end
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         irq_mask_q <= CHANGE_IRQ_MASK_RST;
      end else begin
         irq_mask_q <= irq_mask_d;
      end
   end

   // =========================================================
   // change status, a change in the read cycle survives the clear
   logic [DATA_W-1:0] status_q;
   logic [DATA_W-1:0] status_d;

   always_comb begin
      status_d = status_q;
      if (rd_status) begin
         status_d = CHANGE_STATUS_RST;
      end
      status_d = status_d | sense.change;
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         status_q <= CHANGE_STATUS_RST;
      end else begin
         status_q <= status_d;
      end
   end

   // disabled pins still collect status, they just stay off the line
   assign o_IRQ = |(status_q & irq_mask_q);

   // =========================================================
   // read path, data valid only in the cycle after the strobe
   logic [DATA_W-1:0] rd_mux;
   logic [DATA_W-1:0] rdata_q;

   always_comb begin
      case (req.addr)
         OUTPUT_DATA_READBACK_OFS: rd_mux = output_data_q;
         PIN_LEVEL_READBACK_OFS: rd_mux = sense.level;
         CHANGE_IRQ_MASK_OFS: rd_mux = irq_mask_q;
         CHANGE_STATUS_OFS: rd_mux = status_q;
         default: rd_mux = UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         rdata_q <= READ_DATA_RST;
      end else if (req.rd) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= READ_DATA_RST;
      end
   end

   assign o_RDATA = rdata_q;

   // =========================================================
   // assertions
   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (I_RST);

   property p_set_output;
      wr_set |=> ((output_data_q & $past(req.wdata)) == $past(req.wdata));
   endproperty
   a_set_output: assert property (p_set_output)
      else $error("set output data not applied");

   property p_clear_output;
      wr_clr |=> ((output_data_q & $past(req.wdata)) == '0);
   endproperty
   a_clear_output: assert property (p_clear_output)
      else $error("clear output data not applied");

   property p_output_readback;
      (req.rd && req.addr == OUTPUT_DATA_READBACK_OFS && !req.wr)
         |=> (o_RDATA == output_data_q);
   endproperty
   a_output_readback: assert property (p_output_readback)
      else $error("output readback mismatch");

   property p_pin_drive;
      ((o_PIN_OE & ~ctrl.owned) == '0) && ((o_PIN_OE & ~ctrl.is_output) == '0);
   endproperty
   a_pin_drive: assert property (p_pin_drive)
      else $error("pin driven while not owned output");

   property p_pin_readback;
      (req.rd && req.addr == PIN_LEVEL_READBACK_OFS)
         |=> (o_RDATA == $past(sense.level));
   endproperty
   a_pin_readback: assert property (p_pin_readback)
      else $error("pin level readback mismatch");

   property p_irq_enable;
      wr_ien |=> ((irq_mask_q & $past(req.wdata)) == $past(req.wdata));
   endproperty
   a_irq_enable: assert property (p_irq_enable)
      else $error("irq enable not applied");

   property p_irq_disable;
      wr_idis |=> ((irq_mask_q & $past(req.wdata)) == '0);
   endproperty
   a_irq_disable: assert property (p_irq_disable)
      else $error("irq disable not applied");

   property p_mask_hold;
      !(wr_ien || wr_idis) |=> $stable(irq_mask_q);
   endproperty
   a_mask_hold: assert property (p_mask_hold)
      else $error("mask changed without write");

   property p_change_sets;
      (sense.change != '0) |=> ((status_q & $past(sense.change)) == $past(sense.change));
   endproperty
   a_change_sets: assert property (p_change_sets)
      else $error("change not recorded in status");

   property p_read_clears;
      (rd_status && sense.change == '0) |=> (status_q == '0);
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("status not cleared by read");

   property p_status_read_value;
      rd_status |=> (o_RDATA == $past(status_q));
   endproperty
   a_status_read_value: assert property (p_status_read_value)
      else $error("status read value wrong");

   property p_irq_level;
      ((status_q & irq_mask_q) != '0) |-> o_IRQ;
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("irq low with unmasked status");

   property p_irq_quiet;
      (irq_mask_q == '0) |-> !o_IRQ;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet)
      else $error("irq high with all pins disabled");

   property p_set_keeps;
      wr_set |=> ((output_data_q & ~$past(req.wdata))
                  == ($past(output_data_q) & ~$past(req.wdata)));
   endproperty
   a_set_keeps: assert property (p_set_keeps)
      else $error("set output data changed a bit written zero");

   property p_clear_keeps;
      wr_clr |=> ((output_data_q & ~$past(req.wdata))
                  == ($past(output_data_q) & ~$past(req.wdata)));
   endproperty
   a_clear_keeps: assert property (p_clear_keeps)
      else $error("clear output data changed a bit written zero");

   property p_output_hold;
      !(wr_set || wr_clr) |=> $stable(output_data_q);
   endproperty
   a_output_hold: assert property (p_output_hold)
      else $error("output data changed without a write");

   property p_pin_enable;
      o_PIN_OE == (ctrl.owned & ctrl.is_output);
   endproperty
   a_pin_enable: assert property (p_pin_enable)
      else $error("owned output pin not driven");

   property p_enable_keeps;
      wr_ien |=> ((irq_mask_q & ~$past(req.wdata))
                  == ($past(irq_mask_q) & ~$past(req.wdata)));
   endproperty
   a_enable_keeps: assert property (p_enable_keeps)
      else $error("irq enable changed a bit written zero");

   property p_disable_keeps;
      wr_idis |=> ((irq_mask_q & ~$past(req.wdata))
                   == ($past(irq_mask_q) & ~$past(req.wdata)));
   endproperty
   a_disable_keeps: assert property (p_disable_keeps)
      else $error("irq disable changed a bit written zero");

   property p_enable_unowned;
      (wr_ien && ((req.wdata & ~ctrl.owned) != '0))
         |=> ((irq_mask_q & $past(req.wdata & ~ctrl.owned)) == $past(req.wdata & ~ctrl.owned));
   endproperty
   a_enable_unowned: assert property (p_enable_unowned)
      else $error("irq enable ignored on a foreign pin");

   property p_disable_unowned;
      (wr_idis && ((req.wdata & ~ctrl.owned) != '0))
         |=> ((irq_mask_q & $past(req.wdata & ~ctrl.owned)) == '0);
   endproperty
   a_disable_unowned: assert property (p_disable_unowned)
      else $error("irq disable ignored on a foreign pin");

   property p_mask_readback;
      (req.rd && req.addr == CHANGE_IRQ_MASK_OFS)
         |=> (o_RDATA == $past(irq_mask_q));
   endproperty
   a_mask_readback: assert property (p_mask_readback)
      else $error("mask readback mismatch");

   property p_status_hold;
      (!rd_status && sense.change == '0) |=> $stable(status_q);
   endproperty
   a_status_hold: assert property (p_status_hold)
      else $error("status changed without event or read");

   property p_status_after_read;
      rd_status |=> (status_q == $past(sense.change));
   endproperty
   a_status_after_read: assert property (p_status_after_read)
      else $error("status after read not limited to new changes");

   property p_no_new_status;
      (sense.change == '0) |=> ((status_q & ~$past(status_q)) == '0);
   endproperty
   a_no_new_status: assert property (p_no_new_status)
      else $error("status bit set without a change");

   property p_irq_off;
      ((status_q & irq_mask_q) == '0) |-> !o_IRQ;
   endproperty
   a_irq_off: assert property (p_irq_off)
      else $error("irq high without unmasked status");

   c_irq_rise: cover property ($rose(o_IRQ));
   c_change_on_read: cover property (rd_status && sense.change != '0);
   c_set_then_clear: cover property (wr_set ##1 wr_clr);
   c_driven_pin: cover property (o_PIN_OE != '0 && o_PIN_OUT != '0);
   c_unowned_enable: cover property (wr_ien && ((req.wdata & ~ctrl.owned) != '0));

endmodule : pio_status_irq

`default_nettype wire

// >>> rtl/pio_status_pkg.sv
package pio_status_pkg;

   // =========================================================
   // widths
   localparam int PIN_COUNT = 32;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // =========================================================
   // register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] SET_OUTPUT_DATA_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] CLEAR_OUTPUT_DATA_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] OUTPUT_DATA_READBACK_OFS = 8'h08;
   localparam logic [ADDR_W-1:0] PIN_LEVEL_READBACK_OFS = 8'h0C;
   localparam logic [ADDR_W-1:0] CHANGE_IRQ_ENABLE_OFS = 8'h10;
   localparam logic [ADDR_W-1:0] CHANGE_IRQ_DISABLE_OFS = 8'h14;
   localparam logic [ADDR_W-1:0] CHANGE_IRQ_MASK_OFS = 8'h18;
   localparam logic [ADDR_W-1:0] CHANGE_STATUS_OFS = 8'h1C;

   // =========================================================
   // reset values
   localparam logic [DATA_W-1:0] OUTPUT_DATA_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] CHANGE_IRQ_MASK_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] CHANGE_STATUS_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] READ_DATA_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;
   localparam logic [PIN_COUNT-1:0] PIN_LEVEL_RST = 32'h0000_0000;

   // =========================================================
   // carriers
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } bus_req_type;

   typedef struct packed {
      logic [PIN_COUNT-1:0] owned;
      logic [PIN_COUNT-1:0] is_output;
   } pin_ctrl_type;

   typedef struct packed {
      logic [PIN_COUNT-1:0] level;
      logic [PIN_COUNT-1:0] change;
   } pin_sense_type;

endpackage : pio_status_pkg
